// *** pkg/cpu_rrss_consts.svh ***
// named constants for the return, rotate, standby and subtract execute slice
`ifndef CPU_RRSS_CONSTS_SVH
`define CPU_RRSS_CONSTS_SVH

// instruction word layout
`define INSTR_W       14
`define OPC_HI_MSB    13
`define OPC_HI_LSB    8
`define DEST_BIT      7
`define FILE_MSB      6
`define FILE_W        7

// full-word opcodes
`define OP_CALL_EXIT  14'h0040
`define OP_STANDBY    14'h0003

// upper six opcode bits of the file-register forms
`define OPC_ROT_LEFT  6'h0d
`define OPC_ROT_RIGHT 6'h0c
`define OPC_SUB_FILE  6'h02

// data path
`define DATA_W        8
`define DATA_MSB      7
`define NIB_MSB       3

// register port map
`define REG_ADDR_W    4
`define REG_CTRL      4'h0
`define REG_ACC       4'h1
`define REG_STATUS    4'h2
`define REG_COUNT     4'h3

// control and status field positions
`define CTRL_EN_BIT   0
`define ST_C_BIT      0
`define ST_DC_BIT     1
`define ST_Z_BIT      2

// reset values, the count step and the program counter width
`define CTRL_RST      8'h01
`define ACC_RST       8'h00
`define COUNT_RST     8'h00
`define COUNT_INC     8'h01
`define DATA_ZERO     8'h00
`define FILE_ZERO     7'h00
`define PC_W          13
`define PC_RST        13'h0000

`endif

// *** pkg/cpu_rrss_pkg.sv ***
// types shared by the execute slice and its arithmetic unit
package cpu_rrss_pkg;

  typedef enum logic [1:0] {
    ALU_NONE,
    ALU_ROT_LEFT,
    ALU_ROT_RIGHT,
    ALU_SUB
  } aluOp_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_CALL_EXIT2,
    ST_STANDBY
  } state_t;

  typedef struct packed {
    logic       carry;
    logic       digitCarry;
    logic       zero;
    logic       timeoutFlag;
    logic       powerDownFlag;
  } flags_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } fileWrite_t;

  typedef struct packed {
    logic [7:0] result;
    logic       carry;
    logic       digitCarry;
    logic       zero;
  } aluOut_t;

endpackage

// *** rtl/cpu_return_rotate_sleep_subtract.sv ***
// execute slice for call exit, rotates through carry, standby and subtract
`timescale 1ns/1ps
`default_nettype none
`include "cpu_rrss_consts.svh"

module cpu_return_rotate_sleep_subtract (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // instruction stream
  input  wire logic                       instrValid,
  input  wire logic [`INSTR_W-1:0]        instrWord,
  output logic                            instrReady,
  // file register access
  output logic [`FILE_W-1:0]              fileAddr,
  input  wire logic [`DATA_W-1:0]         fileRdata,
  output var  cpu_rrss_pkg::fileWrite_t   fileWr,
  // hardware stack and program counter
  input  wire logic [`PC_W-1:0]           stackTop,
  output logic                            stackPop,
  output logic                            pcLoad,
  output logic [`PC_W-1:0]                pcValue,
  // standby
  input  wire logic                       wakeEvent,
  output logic                            oscStop,
  // core state
  output logic [`DATA_W-1:0]              accOut,
  output var  cpu_rrss_pkg::flags_t       flags,
  // register port
  input  wire logic [`REG_ADDR_W-1:0]     regAddr,
  input  wire logic [`DATA_W-1:0]         regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic [`DATA_W-1:0]              regRdata
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  cpu_rrss_pkg::state_t     stateQ;
  cpu_rrss_pkg::state_t     stateD;
  cpu_rrss_pkg::fileWrite_t fileWrQ;
  cpu_rrss_pkg::aluOut_t    aluRes;
  cpu_rrss_pkg::aluOp_t     aluOp;

  logic [`DATA_W-1:0] ctrlQ;
  logic [`DATA_W-1:0] accQ;
  logic [`DATA_W-1:0] countQ;
  logic [`DATA_W-1:0] regRdataQ;
  logic               fileWeQ;
  logic [`FILE_W-1:0] fileAddrQ;
  logic [`DATA_W-1:0] fileDataQ;
  logic [`PC_W-1:0]   pcValueQ;
  logic               pcLoadQ;
  logic               carryQ;
  logic               digitCarryQ;
  logic               zeroQ;
  logic               timeoutFlagQ;
  logic               powerDownFlagQ;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire [5:0]              opcHigh    = instrWord[`OPC_HI_MSB:`OPC_HI_LSB];
  wire                    isCallExit = (instrWord == `OP_CALL_EXIT);
  wire                    isStandby  = (instrWord == `OP_STANDBY);
  wire                    isRotLeft  = (opcHigh == `OPC_ROT_LEFT);
  wire                    isRotRight = (opcHigh == `OPC_ROT_RIGHT);
  wire                    isSubFile  = (opcHigh == `OPC_SUB_FILE);
  wire                    isFileOp   = isRotLeft | isRotRight | isSubFile;
  wire                    destFile   = instrWord[`DEST_BIT];
  wire [`FILE_W-1:0]      fileSel    = instrWord[`FILE_MSB:0];
  wire                    enabled    = ctrlQ[`CTRL_EN_BIT];

  // only the run state takes a word; the second call-exit cycle and standby hold off
  wire                    ready      = enabled && (stateQ == cpu_rrss_pkg::ST_RUN);
  wire                    accept     = instrValid && ready;
  wire                    doCallExit = accept && isCallExit;
  wire                    doStandby  = accept && isStandby;
  wire                    doFileOp   = accept && isFileOp;
  wire                    doSub      = accept && isSubFile;
  wire                    toAcc      = doFileOp && !destFile;
  wire                    toFile     = doFileOp && destFile;

  assign aluOp = isRotLeft  ? cpu_rrss_pkg::ALU_ROT_LEFT  :
                 isRotRight ? cpu_rrss_pkg::ALU_ROT_RIGHT :
                 isSubFile  ? cpu_rrss_pkg::ALU_SUB       :
                              cpu_rrss_pkg::ALU_NONE;

  // a file write still in flight lands only at the end of this cycle, so a
  // back-to-back access to the same address takes the pending value
  wire                    fwdHit     = fileWrQ.we && (fileWrQ.addr == fileSel);
  wire [`DATA_W-1:0]      fileVal    = fwdHit ? fileWrQ.data : fileRdata;

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  wire                    wrCtrl     = regWr && (regAddr == `REG_CTRL);
  wire                    wrAcc      = regWr && (regAddr == `REG_ACC);
  wire                    wrStatus   = regWr && (regAddr == `REG_STATUS);
  wire                    busy       = (stateQ == cpu_rrss_pkg::ST_CALL_EXIT2);
  wire                    inStandby  = (stateQ == cpu_rrss_pkg::ST_STANDBY);
  wire [`DATA_W-1:0]      statusWord = {1'b0, busy, inStandby, powerDownFlagQ,
                                        timeoutFlagQ, zeroQ, digitCarryQ, carryQ};
  wire [`DATA_W-1:0]      readMux    = (regAddr == `REG_CTRL)   ? ctrlQ      :
                                       (regAddr == `REG_ACC)    ? accQ       :
                                       (regAddr == `REG_STATUS) ? statusWord :
                                       (regAddr == `REG_COUNT)  ? countQ     :
                                                                  `DATA_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic

  file_alu u_alu (
    .fileVal (fileVal),
    .accVal  (accQ),
    .carryIn (carryQ),
    .op      (aluOp),
    .res     (aluRes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      cpu_rrss_pkg::ST_RUN: begin
        if (doCallExit) begin
          stateD = cpu_rrss_pkg::ST_CALL_EXIT2;
        end else if (doStandby) begin
          stateD = cpu_rrss_pkg::ST_STANDBY;
        end
      end
      cpu_rrss_pkg::ST_CALL_EXIT2: begin
        stateD = cpu_rrss_pkg::ST_RUN;
      end
      cpu_rrss_pkg::ST_STANDBY: begin
        if (wakeEvent) begin
          stateD = cpu_rrss_pkg::ST_RUN;
        end
      end
      default: begin
        stateD = cpu_rrss_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stateQ <= cpu_rrss_pkg::ST_RUN;
    end else begin
      stateQ <= stateD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter from the stack

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pcLoadQ <= 1'b0;
    end else begin
      pcLoadQ <= doCallExit;
    end
  end

  // the popped value holds until the next call exit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pcValueQ <= `PC_RST;
    end else if (doCallExit) begin
      pcValueQ <= stackTop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // results

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fileWeQ <= 1'b0;
    end else begin
      fileWeQ <= toFile;
    end
  end

  // address and data move only with a write; the strobe alone marks a live write-back
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fileAddrQ <= `FILE_ZERO;
      fileDataQ <= `DATA_ZERO;
    end else if (toFile) begin
      fileAddrQ <= fileSel;
      fileDataQ <= aluRes.result;
    end
  end

  assign fileWrQ = '{we: fileWeQ, addr: fileAddrQ, data: fileDataQ};

  // an instruction result wins over a software write in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      accQ <= `ACC_RST;
    end else if (toAcc) begin
      accQ <= aluRes.result;
    end else if (wrAcc) begin
      accQ <= regWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: call exit touches none, rotates only carry

  always_ff @(posedge core_clk) begin
    if (rst) begin
      carryQ <= 1'b0;
    end else if (doFileOp) begin
      carryQ <= aluRes.carry;
    end else if (wrStatus) begin
      carryQ <= regWdata[`ST_C_BIT];
    end
  end

  // rotates leave digit carry and zero alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      digitCarryQ <= 1'b0;
      zeroQ       <= 1'b0;
    end else if (doSub) begin
      digitCarryQ <= aluRes.digitCarry;
      zeroQ       <= aluRes.zero;
    end else if (wrStatus) begin
      digitCarryQ <= regWdata[`ST_DC_BIT];
      zeroQ       <= regWdata[`ST_Z_BIT];
    end
  end

  // power-down reads low while asleep; wake leaves both as standby set them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timeoutFlagQ   <= 1'b1;
      powerDownFlagQ <= 1'b1;
    end else if (doStandby) begin
      timeoutFlagQ   <= 1'b1;
      powerDownFlagQ <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrlQ <= `CTRL_RST;
    end else if (wrCtrl) begin
      ctrlQ <= regWdata;
    end
  end

  // counts every accepted word, decoded or not, and wraps
  always_ff @(posedge core_clk) begin
    if (rst) begin
      countQ <= `COUNT_RST;
    end else if (accept) begin
      countQ <= countQ + `COUNT_INC;
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdataQ <= `DATA_ZERO;
    end else begin
      regRdataQ <= regRd ? readMux : `DATA_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign instrReady = ready;
  assign fileAddr   = fileSel;
  assign fileWr     = fileWrQ;
  assign stackPop   = doCallExit;
  assign pcLoad     = pcLoadQ;
  assign pcValue    = pcValueQ;
  assign oscStop    = inStandby;
  assign accOut     = accQ;
  assign flags      = '{carry: carryQ, digitCarry: digitCarryQ, zero: zeroQ,
                        timeoutFlag: timeoutFlagQ, powerDownFlag: powerDownFlagQ};
  assign regRdata   = regRdataQ;

endmodule
`default_nettype wire

// *** rtl/file_alu.sv ***
// rotate-through-carry and subtract arithmetic for the execute slice
`timescale 1ns/1ps
`default_nettype none
`include "cpu_rrss_consts.svh"

module file_alu (
  // operation and operands
  input  wire logic [`DATA_W-1:0]       fileVal,
  input  wire logic [`DATA_W-1:0]       accVal,
  input  wire logic                     carryIn,
  input  wire cpu_rrss_pkg::aluOp_t     op,
  // result and flags
  output var  cpu_rrss_pkg::aluOut_t    res
);

  logic [`DATA_W:0]    diffFull;
  logic [`NIB_MSB+1:0] diffNib;
  logic [`DATA_W-1:0]  rotLeft;
  logic [`DATA_W-1:0]  rotRight;
  logic [`DATA_W-1:0]  resultSel;
  logic                carrySel;

  // carry enters at the vacated end, the bit shifted out becomes carry
  assign rotLeft  = {fileVal[`DATA_MSB-1:0], carryIn};
  assign rotRight = {carryIn, fileVal[`DATA_MSB:1]};

  // nine-bit difference: the top bit is the borrow
  assign diffFull = {1'b0, fileVal} - {1'b0, accVal};
  assign diffNib  = {1'b0, fileVal[`NIB_MSB:0]} - {1'b0, accVal[`NIB_MSB:0]};

  assign resultSel = (op == cpu_rrss_pkg::ALU_ROT_LEFT)  ? rotLeft  :
                     (op == cpu_rrss_pkg::ALU_ROT_RIGHT) ? rotRight :
                     (op == cpu_rrss_pkg::ALU_SUB)       ? diffFull[`DATA_W-1:0] :
                                                           fileVal;
  assign carrySel  = (op == cpu_rrss_pkg::ALU_ROT_LEFT)  ? fileVal[`DATA_MSB] :
                     (op == cpu_rrss_pkg::ALU_ROT_RIGHT) ? fileVal[0] :
                     (op == cpu_rrss_pkg::ALU_SUB)       ? ~diffFull[`DATA_W] :
                                                           carryIn;

  assign res.result     = resultSel;
  assign res.carry      = carrySel;
  // carry and digit carry read as no-borrow
  assign res.digitCarry = ~diffNib[`NIB_MSB+1];
  assign res.zero       = (diffFull[`DATA_W-1:0] == `DATA_ZERO);

endmodule
`default_nettype wire

// *** testbench/cpu_return_rotate_sleep_subtract_tb_top.sv ***
// self-checking bench for the execute slice
`timescale 1ns/1ps
`default_nettype none
`include "cpu_rrss_consts.svh"
module cpu_return_rotate_sleep_subtract_tb_top;
  logic                     core_clk, rst, instrValid, wakeEvent, regWr, regRd;
  logic [13:0]              instrWord;
  logic [7:0]               regWdata, fileRdata, acc;
  logic [3:0]               regAddr;
  logic [12:0]              stackTop;
  wire                      instrReady, stackPop, pcLoad, oscStop;
  wire  [6:0]               fileAddr;
  wire  [7:0]               accOut, regRdata;
  wire  [12:0]              pcValue;
  cpu_rrss_pkg::fileWrite_t fileWr;
  cpu_rrss_pkg::flags_t     flags;
  logic [7:0]               mem [128];
  logic [7:0]               mdl [128];
  logic                     c, dc, z, pend, expWe;
  logic [6:0]               expAddr;
  logic [7:0]               expData;
  logic [7:0]               acceptCount;
  int                       errors, check_count;
  cpu_return_rotate_sleep_subtract dut (.core_clk, .rst, .instrValid, .instrWord, .instrReady, .fileAddr,
    .fileRdata, .fileWr, .stackTop, .stackPop, .pcLoad, .pcValue, .wakeEvent, .oscStop, .accOut, .flags,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata);
  assign fileRdata = mem[fileAddr];
  always @(posedge core_clk) if (fileWr.we) mem[fileWr.addr] <= fileWr.data;
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // returns result, carry, digit carry, zero; carry means no borrow
  function automatic logic [10:0] alu(input logic [13:0] w, input logic [7:0] f, a, input logic ci, di, zi);
    logic [7:0] r;
    r = f - a;
    case (w[13:8])
      `OPC_ROT_LEFT:  return {f[6:0], ci, f[7], di, zi};
      `OPC_ROT_RIGHT: return {ci, f[7:1], f[0], di, zi};
      `OPC_SUB_FILE:  return {r, f >= a, f[3:0] >= a[3:0], r == 8'h00};
      default:        return {a, ci, di, zi};
    endcase
  endfunction
  // leaves the word offered so the next call may follow back to back
  task automatic exec(input logic [13:0] w);
    logic [10:0] o;
    logic        ff;
    ff = w[13:8] inside {`OPC_ROT_LEFT, `OPC_ROT_RIGHT, `OPC_SUB_FILE};
    o = alu(w, mdl[w[6:0]], acc, c, dc, z);
    instrValid <= 1;
    instrWord <= w;
    @(negedge core_clk);
    for (int i = 0; i < 40 && instrReady !== 1'b1; i++) @(negedge core_clk);
    check(instrReady, 1'b1);
    check(stackPop, w == `OP_CALL_EXIT);
    @(posedge core_clk);
    acceptCount++;
    expWe = ff && w[7];
    expAddr = w[6:0];
    expData = o[10:3];
    if (ff) begin
      {c, dc, z} = o[2:0];
      if (w[7]) mdl[w[6:0]] = o[10:3];
      else acc = o[10:3];
    end
    pend = 1;
  endtask
  always @(negedge core_clk) if (pend) begin
    pend = 0;
    check(accOut, acc);
    check({flags.carry, flags.digitCarry, flags.zero}, {c, dc, z});
    check(fileWr.we, expWe);
    if (expWe) check({fileWr.addr, fileWr.data}, {expAddr, expData});
  end
  task automatic idle(input int n);
    instrValid <= 0;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wrreg(input logic [3:0] a, input logic [7:0] d);
    regWr <= 1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 0;
  endtask
  task automatic rdreg(input logic [3:0] a, output logic [7:0] d);
    regRd <= 1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 0;
    @(negedge core_clk);
    d = regRdata;
    @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    logic [7:0]  d;
    logic [13:0] w;
    logic [5:0]  ops [4];
    ops = '{`OPC_ROT_LEFT, `OPC_ROT_RIGHT, `OPC_SUB_FILE, 6'h0e};
    w = 14'($urandom(32'he47822b8));
    {rst, instrValid, instrWord, wakeEvent, regWr, regRd, regAddr, regWdata, stackTop} = {1'b1, 43'h0};
    {acc, c, dc, z, pend, errors, check_count, acceptCount} = 0;
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'($urandom);
      mdl[i] = mem[i];
    end
    repeat (16) @(posedge core_clk);
    rst <= 0;
    @(negedge core_clk);
    check({accOut, flags, oscStop, instrReady}, {8'h00, 5'b00011, 2'b01});
    @(posedge core_clk);
    rdreg(`REG_CTRL, d);
    check(d, 8'h01);
    rdreg(4'hf, d);
    check(d, 8'h00);
    // rotate example then same-address subtracts that need forwarding
    mem[5] = 8'he6;
    mdl[5] = 8'he6;
    exec(14'h0d05);
    exec(14'h0c85);
    idle(1);
    wrreg(`REG_ACC, 8'h02);
    acc = 8'h02;
    mem[5] = 8'h03;
    mdl[5] = 8'h03;
    repeat (3) exec(14'h0285);
    w = 14'($urandom);
    stackTop <= w[12:0];
    exec(`OP_CALL_EXIT);
    idle(0);
    @(negedge core_clk);
    check({pcLoad, pcValue, instrReady}, {1'b1, w[12:0], 1'b0});
    @(negedge core_clk);
    check(instrReady, 1'b1);
    @(posedge core_clk);
    exec(`OP_STANDBY);
    idle(0);
    @(negedge core_clk);
    check({oscStop, flags.timeoutFlag, flags.powerDownFlag, instrReady}, 4'b1100);
    @(posedge core_clk);
    rdreg(`REG_STATUS, d);
    check(d[6:3], 4'b0101);
    wakeEvent <= 1;
    @(posedge core_clk);
    wakeEvent <= 0;
    @(negedge core_clk);
    check({oscStop, instrReady}, 2'b01);
    @(posedge core_clk);
    rdreg(`REG_STATUS, d);
    check(d[4:0], {2'b01, z, dc, c});
    wrreg(`REG_CTRL, 8'h00);
    @(negedge core_clk);
    check(instrReady, 1'b0);
    @(posedge core_clk);
    wrreg(`REG_CTRL, 8'h01);
    repeat (300) begin
      w = 14'($urandom);
      if (w[13:12] == 2'b00) begin
        idle(1);
        d = 8'($urandom);
        wrreg(`REG_ACC, d);
        acc = d;
      end else
        exec({ops[w[11:10]], w[7], w[6:3] & {4{w[8]}}, w[2:0]});
    end
    idle(3);
    rdreg(`REG_COUNT, d);
    check(d, acceptCount);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** testbench/cpu_rrss_assertions.sv ***
// assertion checker for the execute slice
`timescale 1ns/1ps
`default_nettype none
`include "cpu_rrss_consts.svh"
module cpu_rrss_assertions (
  // clock and reset
  input wire logic                     core_clk,
  input wire logic                     rst,
  // watched ports
  input wire logic                     instrValid,
  input wire logic [`INSTR_W-1:0]      instrWord,
  input wire logic                     instrReady,
  input wire logic [`FILE_W-1:0]       fileAddr,
  input wire logic [`DATA_W-1:0]       fileRdata,
  input wire cpu_rrss_pkg::fileWrite_t fileWr,
  input wire logic [`PC_W-1:0]         stackTop,
  input wire logic                     stackPop,
  input wire logic                     pcLoad,
  input wire logic [`PC_W-1:0]         pcValue,
  input wire logic                     wakeEvent,
  input wire logic                     oscStop,
  input wire logic [`DATA_W-1:0]       accOut,
  input wire cpu_rrss_pkg::flags_t     flags,
  input wire logic                     regWr
);
  logic dest_q;
  wire       take = instrValid && instrReady;
  wire [5:0] opc  = instrWord[13:8];
  // a pending write-back is the true operand when the address repeats
  wire [7:0] opnd = (fileWr.we && fileWr.addr == fileAddr) ? fileWr.data : fileRdata;
  wire [7:0] dif  = opnd - accOut;
  wire [7:0] res  = dest_q ? fileWr.data : accOut;
  wire       rot  = take && (opc == `OPC_ROT_LEFT || opc == `OPC_ROT_RIGHT);
  wire       sub  = take && opc == `OPC_SUB_FILE;
  always_ff @(posedge core_clk) dest_q <= instrWord[7];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_exit;
    take && instrWord == `OP_CALL_EXIT;
  endsequence
  sequence s_gap;
    !instrReady ##1 instrReady;
  endsequence
  a_exit_pop: assert property (s_exit |-> stackPop)
    else $error("no pop on call exit");
  a_exit_pc: assert property (s_exit |=> pcLoad && pcValue == $past(stackTop))
    else $error("pc not loaded from stack top");
  a_exit_flags: assert property (s_exit ##0 !regWr |=> flags == $past(flags))
    else $error("call exit changed flags");
  a_exit_gap: assert property (s_exit ##0 !regWr ##1 !regWr |-> s_gap)
    else $error("call exit not two cycles");
  a_rot_left: assert property (take && opc == `OPC_ROT_LEFT |=>
    res == {$past(opnd[6:0]), $past(flags.carry)} && flags.carry == $past(opnd[7]))
    else $error("rotate left wrong");
  a_rot_right: assert property (take && opc == `OPC_ROT_RIGHT |=>
    res == {$past(flags.carry), $past(opnd[7:1])} && flags.carry == $past(opnd[0]))
    else $error("rotate right wrong");
  a_rot_keep: assert property (rot && !regWr |=> $stable({flags.digitCarry, flags.zero}))
    else $error("rotate touched other flags");
  a_dest_file: assert property ((rot || sub) && instrWord[7] |=>
    fileWr.we && fileWr.addr == $past(instrWord[6:0]))
    else $error("file write missing");
  a_dest_acc: assert property ((rot || sub) && !instrWord[7] |=> !fileWr.we)
    else $error("file written for accumulator result");
  a_sub_value: assert property (sub |=> res == $past(dif) && flags.zero == $past(dif == 8'h00))
    else $error("subtract result wrong");
  a_sub_borrow: assert property (sub |=> flags.carry == $past(opnd >= accOut) &&
    flags.digitCarry == $past(opnd[3:0] >= accOut[3:0]))
    else $error("subtract borrow flags wrong");
  a_standby_in: assert property (take && instrWord == `OP_STANDBY |=>
    oscStop && flags.timeoutFlag && !flags.powerDownFlag && !instrReady)
    else $error("standby entry wrong");
  a_standby_wake: assert property (oscStop |=> oscStop != $past(wakeEvent))
    else $error("standby exit wrong");
endmodule
bind cpu_return_rotate_sleep_subtract cpu_rrss_assertions chk (.core_clk, .rst, .instrValid, .instrWord,
  .instrReady, .fileAddr, .fileRdata, .fileWr, .stackTop, .stackPop, .pcLoad, .pcValue, .wakeEvent,
  .oscStop, .accOut, .flags, .regWr);
`default_nettype wire
